/* inc/bpsr_defines.svh */
// Register offsets, field positions, reset values and timing counts for the
// bus parity and DRAM self-refresh block. Included by the design modules and
// the testbench; holds definitions only.
`ifndef BPSR_DEFINES_SVH
`define BPSR_DEFINES_SVH

// Register byte offsets on the APB slave
`define BPSR_OFF_PARITY 12'h000
`define BPSR_OFF_REFRESH 12'h004
`define BPSR_OFF_STANDBY 12'h008
`define BPSR_OFF_WAIT1 12'h00c
`define BPSR_OFF_WAIT2 12'h010
`define BPSR_OFF_WAIT3 12'h014
`define BPSR_OFF_STATUS 12'h018
`define BPSR_OFF_MASK 12'h01c

// Parity control field positions
`define BPSR_PEF_BIT 15
`define BPSR_PARITY_FORCE_OUTPUT_BIT 14
`define BPSR_POL_BIT 13
`define BPSR_CHK_HI 12
`define BPSR_CHK_LO 11
`define BPSR_PARITY_RW_MASK 16'h7800
`define BPSR_PARITY_RESET 16'h0000

// Refresh control field positions
`define BPSR_RF_EN_BIT 0
`define BPSR_RF_KIND_BIT 1
`define BPSR_SBY_BIT 0

// Status bits: parity error, self-refresh entered, self-refresh left
`define BPSR_ST_PERR 0
`define BPSR_ST_SR_IN 1
`define BPSR_ST_SR_OUT 2
`define BPSR_ST_W 3

// Strobe timing: column-to-row lead in ns and its count at 250 MHz
`define BPSR_CLK_MHZ 250
`define BPSR_T_CR_NS 8
`define BPSR_CR_CYC ((`BPSR_T_CR_NS * `BPSR_CLK_MHZ + 999) / 1000)

`endif

/* inc/bpsr_pkg.sv */
// Types shared by the bus parity and self-refresh block.
// Assumes bpsr_defines.svh is on the include path.
package bpsr_pkg;
  // Self-refresh strobe sequencer states
  typedef enum logic [2:0] {
    BPSR_SR_IDLE,
    BPSR_SR_CAS,
    BPSR_SR_HOLD,
    BPSR_SR_RAS_UP,
    BPSR_SR_CAS_UP
  } bpsr_sr_state_t;
endpackage

/* logic/bpsr_wait_gen.sv */
// Per-area bus cycle length and wait-pin sampling from three wait registers.
// Assumes the caller gives an area number and a one-cycle start pulse.
`timescale 1ns/1ps
`default_nettype none
`include "bpsr_defines.svh"
module bpsr_wait_gen
  import bpsr_pkg::*;
#(
  parameter int AREAS = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] wait_cfg1,
  input wire logic [15:0] wait_cfg2,
  input wire logic [15:0] wait_cfg3,
  input wire logic [2:0] area,
  input wire logic start,
  input wire logic wait_in,
  output logic busy
);
  // Remaining base states of the current cycle
  logic [3:0] left;
  // Whether the pin is honoured in this cycle
  logic samp;

  // wait_cfg1 bit n enables pin sampling for area n; wait_cfg2 holds a
  // 2-bit extra state count per area and wait_cfg3 bit n adds one state
  // more, so an area can run from one to five base states
  function automatic logic [1:0] extra_of(input logic [15:0] c, input logic [2:0] a);
    extra_of = c[{a, 1'b0} +: 2];
  endfunction

  // Cycle counter; wait pin stretches the last state while sampled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left <= 4'h0;
      samp <= 1'b0;
      busy <= 1'b0;
    end
    else if (start)
    begin
      left <= 4'h1 + {2'b00, extra_of(wait_cfg2, area)} + {3'b000, wait_cfg3[area]};
      samp <= wait_cfg1[area];
      busy <= 1'b1;
    end
    else if (busy)
    begin
      // Wait pin holds the final state only when sampling is enabled
      if (left == 4'h0 && !(samp && wait_in))
        busy <= 1'b0;
      else if (left != 4'h0)
        left <= left - 4'h1;
    end
  end
endmodule
`default_nettype wire

/* logic/bpsr_top.sv */
// What this block does
// - 16-bit parity register selects space, stores polarity bit unused
// - Parity register clears only on power-on reset
// - Top bit reads one after parity error
// - Flag clears by read-one then write-zero
// - Both refresh bits set enter self-refresh
// - Clearing kind bit exits self-refresh
// - Standby with self-refresh keeps DRAM refreshed
// - Refresh may overlap a running bus cycle
// - Wait registers set per-area states, sampling
//
// Top of the bus parity and DRAM self-refresh block, an APB slave.
// Assumes an external parity checker, pin inputs to be synchronised, and a
// separate power-on reset qualifier (por_n) sampled on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "bpsr_defines.svh"
module bpsr_top
  import bpsr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic parity_err_in,
  input wire logic [1:0] access_space,
  input wire logic ext_access,
  input wire logic [2:0] access_area,
  input wire logic wait_pin,
  input wire logic halt,
  output logic ras_n,
  output logic cas_n,
  output logic standby,
  output logic bus_busy,
  output logic irq
);
  // Register state
  logic [15:0] parity_control;
  logic [1:0] refresh_control;
  logic standby_control;
  logic [15:0] wait_cfg1, wait_cfg2, wait_cfg3;
  logic [`BPSR_ST_W-1:0] irq_status, irq_mask;
  // Set when software has read the flag as one; arms the clear
  logic pef_seen;
  // Pin synchronisers: first stage read only by the second
  logic [1:0] perr_sync, wait_sync;
  // Self-refresh sequencer
  bpsr_sr_state_t sr_state;
  logic [3:0] sr_cnt;
  logic sr_active;
  logic busy_w;
  // Power-on reset seen: por_n low during presetn low forces power-on clear
  logic por_pending;
  // Power-on qualifier pin after two stages, and the power-on clear it allows
  logic [1:0] por_sync;
  logic por_clr;

  // APB decode
  logic acc, wr, rd;
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // Low 16 bits merged under byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  logic known;
  assign known = hit(paddr, `BPSR_OFF_PARITY) || hit(paddr, `BPSR_OFF_REFRESH) ||
                 hit(paddr, `BPSR_OFF_STANDBY) || hit(paddr, `BPSR_OFF_WAIT1) ||
                 hit(paddr, `BPSR_OFF_WAIT2) || hit(paddr, `BPSR_OFF_WAIT3) ||
                 hit(paddr, `BPSR_OFF_STATUS) || hit(paddr, `BPSR_OFF_MASK);

  // Synchronise pin inputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      perr_sync <= 2'b00;
      wait_sync <= 2'b00;
    end
    else
    begin
      perr_sync <= {perr_sync[0], parity_err_in};
      wait_sync <= {wait_sync[0], wait_pin};
    end
  end

  // Parity error qualified by a checked space; hi/lo select which space
  logic chk_on, perr_evt;
  assign chk_on = (parity_control[`BPSR_CHK_HI:`BPSR_CHK_LO] != 2'b00) &&
                  (access_space == parity_control[`BPSR_CHK_HI:`BPSR_CHK_LO]);
  assign perr_evt = perr_sync[1] && ext_access && chk_on;
  // Written value, only the writable control bits kept
  logic [15:0] par_wval;
  assign par_wval = merge16(parity_control, pwdata, pstrb) & `BPSR_PARITY_RW_MASK;

  // Power-on qualifier caught under the async reset and at the first edge after release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      por_pending <= 1'b1;
    else
      por_pending <= 1'b0;
  end

  // Qualifier synchroniser has no reset: it must carry por_n through presetn low
  always_ff @(posedge pclk)
  begin
    por_sync <= {por_sync[0], por_n};
  end
  assign por_clr = por_pending && !por_sync[1];

  // Parity control: kept over a manual reset, cleared on power-on only.
  // Reason: presetn is also the manual reset, so it cannot clear this register.
  always_ff @(posedge pclk)
  begin
    if (por_clr)
      parity_control <= `BPSR_PARITY_RESET;
    else
    begin
      if (wr && hit(paddr, `BPSR_OFF_PARITY))
        parity_control[14:0] <= par_wval[14:0];
      // Set wins over the armed clear; writing one never sets
      if (perr_evt)
        parity_control[`BPSR_PEF_BIT] <= 1'b1;
      else if (wr && hit(paddr, `BPSR_OFF_PARITY) && pstrb[1] && pef_seen &&
               !pwdata[`BPSR_PEF_BIT])
        parity_control[`BPSR_PEF_BIT] <= 1'b0;
    end
  end

  // Clear arming: a read that returns the flag as one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pef_seen <= 1'b0;
    else if (rd && hit(paddr, `BPSR_OFF_PARITY) && parity_control[`BPSR_PEF_BIT])
      pef_seen <= 1'b1;
    else if (wr && hit(paddr, `BPSR_OFF_PARITY))
      pef_seen <= 1'b0;
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      refresh_control <= 2'b00;
      standby_control <= 1'b0;
      wait_cfg1 <= 16'hffff;
      wait_cfg2 <= 16'hffff;
      wait_cfg3 <= 16'h0000;
      irq_mask <= 3'h0;
    end
    else if (wr)
    begin
      if (hit(paddr, `BPSR_OFF_REFRESH) && pstrb[0])
        refresh_control <= pwdata[1:0];
      if (hit(paddr, `BPSR_OFF_STANDBY) && pstrb[0])
        standby_control <= pwdata[`BPSR_SBY_BIT];
      if (hit(paddr, `BPSR_OFF_WAIT1))
        wait_cfg1 <= merge16(wait_cfg1, pwdata, pstrb);
      if (hit(paddr, `BPSR_OFF_WAIT2))
        wait_cfg2 <= merge16(wait_cfg2, pwdata, pstrb);
      if (hit(paddr, `BPSR_OFF_WAIT3))
        wait_cfg3 <= merge16(wait_cfg3, pwdata, pstrb);
      if (hit(paddr, `BPSR_OFF_MASK) && pstrb[0])
        irq_mask <= pwdata[`BPSR_ST_W-1:0];
    end
  end

  // Self-refresh request: both bits high
  logic sr_req;
  assign sr_req = refresh_control[`BPSR_RF_EN_BIT] && refresh_control[`BPSR_RF_KIND_BIT];

  // Strobe sequencer: CAS falls, RAS follows after the lead time and both
  // hold; on exit RAS rises first, then CAS. Runs independent of bus cycles.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sr_state <= BPSR_SR_IDLE;
      sr_cnt <= 4'h0;
      ras_n <= 1'b1;
      cas_n <= 1'b1;
    end
    else
    begin
      unique case (sr_state)
        BPSR_SR_IDLE:
        begin
          if (sr_req)
          begin
            cas_n <= 1'b0;
            sr_cnt <= 4'(`BPSR_CR_CYC);
            sr_state <= BPSR_SR_CAS;
          end
        end
        BPSR_SR_CAS:
        begin
          if (sr_cnt > 4'h1)
            sr_cnt <= sr_cnt - 4'h1;
          else
          begin
            ras_n <= 1'b0;
            sr_state <= BPSR_SR_HOLD;
          end
        end
        BPSR_SR_HOLD:
        begin
          // Standby holds the strobes while the kind bit stays set
          if (!refresh_control[`BPSR_RF_KIND_BIT])
          begin
            ras_n <= 1'b1;
            sr_cnt <= 4'(`BPSR_CR_CYC);
            sr_state <= BPSR_SR_RAS_UP;
          end
        end
        BPSR_SR_RAS_UP:
        begin
          if (sr_cnt > 4'h1)
            sr_cnt <= sr_cnt - 4'h1;
          else
          begin
            cas_n <= 1'b1;
            sr_state <= BPSR_SR_CAS_UP;
          end
        end
        BPSR_SR_CAS_UP:
          sr_state <= BPSR_SR_IDLE;
      endcase
    end
  end
  assign sr_active = (sr_state == BPSR_SR_HOLD);

  // Standby entry on halt with standby bit; self-refresh strobes are held
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      standby <= 1'b0;
    else if (halt && standby_control)
      standby <= 1'b1;
    else if (!halt)
      standby <= 1'b0;
  end

  // Per-area wait generator; bus cycles start alongside refresh
  bpsr_wait_gen #(.AREAS(8)) u_wait (
    .pclk(pclk),
    .presetn(presetn),
    .wait_cfg1(wait_cfg1),
    .wait_cfg2(wait_cfg2),
    .wait_cfg3(wait_cfg3),
    .area(access_area),
    .start(ext_access && !busy_w && !standby),
    .wait_in(wait_sync[1]),
    .busy(busy_w)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bus_busy <= 1'b0;
    else
      bus_busy <= busy_w;
  end

  // Interrupt status: set wins over write-one-clear
  logic sr_active_d;
  logic [`BPSR_ST_W-1:0] evts;
  assign evts = {!sr_active && sr_active_d, sr_active && !sr_active_d, perr_evt};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= 3'h0;
      sr_active_d <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      sr_active_d <= sr_active;
      if (wr && hit(paddr, `BPSR_OFF_STATUS) && pstrb[0])
        irq_status <= (irq_status & ~pwdata[`BPSR_ST_W-1:0]) | evts;
      else
        irq_status <= irq_status | evts;
      irq <= |(irq_status & irq_mask);
    end
  end

  // Read data and ready: no wait state, answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= !known;
      unique case (1'b1)
        hit(paddr, `BPSR_OFF_PARITY): prdata <= {16'h0000, parity_control};
        hit(paddr, `BPSR_OFF_REFRESH): prdata <= {30'h0, refresh_control};
        hit(paddr, `BPSR_OFF_STANDBY): prdata <= {31'h0, standby_control};
        hit(paddr, `BPSR_OFF_WAIT1): prdata <= {16'h0000, wait_cfg1};
        hit(paddr, `BPSR_OFF_WAIT2): prdata <= {16'h0000, wait_cfg2};
        hit(paddr, `BPSR_OFF_WAIT3): prdata <= {16'h0000, wait_cfg3};
        hit(paddr, `BPSR_OFF_STATUS): prdata <= {28'h0, sr_active, irq_status};
        hit(paddr, `BPSR_OFF_MASK): prdata <= {29'h0, irq_mask};
        default: prdata <= 32'h00000000;
      endcase
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Flag set by error reads back one by the next cycle
  a_pef_sets: assert property (@(posedge pclk) disable iff (!presetn)
    perr_evt |=> parity_control[`BPSR_PEF_BIT]) else $error("parity flag not set");
  a_pef_noset: assert property (@(posedge pclk) disable iff (!presetn)
    !parity_control[`BPSR_PEF_BIT] && !perr_evt |=> !parity_control[`BPSR_PEF_BIT])
    else $error("parity flag set without error");
  a_pef_clear: assert property (@(posedge pclk) disable iff (!presetn)
    parity_control[`BPSR_PEF_BIT] && !perr_evt && !pef_seen && !por_clr |=>
    parity_control[`BPSR_PEF_BIT])
    else $error("flag cleared without prior read");
  a_sr_entry: assert property (@(posedge pclk) disable iff (!presetn)
    sr_state == BPSR_SR_IDLE && sr_req |=> !cas_n ##[1:8] !ras_n)
    else $error("self-refresh entry sequence wrong");
  a_sr_exit: assert property (@(posedge pclk) disable iff (!presetn)
    sr_active && !refresh_control[`BPSR_RF_KIND_BIT] |=> ras_n && !cas_n ##[1:8] cas_n)
    else $error("self-refresh exit sequence wrong");
  a_sr_standby: assert property (@(posedge pclk) disable iff (!presetn)
    sr_active && standby && refresh_control[`BPSR_RF_KIND_BIT] |=> !ras_n && !cas_n)
    else $error("self-refresh lost in standby");
  a_stby_enter: assert property (@(posedge pclk) disable iff (!presetn)
    halt && standby_control |=> standby) else $error("standby not entered");
  a_par_rw: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit(paddr, `BPSR_OFF_PARITY) && pstrb[1] && !por_clr |=>
    parity_control[13] == $past(pwdata[13])) else $error("polarity not written");
  a_wait_busy: assert property (@(posedge pclk) disable iff (!presetn)
    ext_access && !busy_w && !standby |=> busy_w) else $error("bus cycle not started");
endmodule
`default_nettype wire

/* testbench/bpsr_dram_model.sv */
// Behavioural external DRAM and memory beside the self-refresh block.
// Assumes one clock; the bench steers parity faults and wait holds.
`timescale 1ns/1ps
`default_nettype none
module bpsr_dram_model
(
  input wire logic pclk,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic bad_parity,
  input wire logic stall,
  output logic parity_err_in,
  output logic wait_pin,
  output int lead_in,
  output int lead_out,
  output logic in_self
);
  logic pc = 1'b1; // Column strobe at the previous edge
  logic pr = 1'b1; // Row strobe at the previous edge
  int cnt = 0; // Cycles since the leading strobe moved
  // Memory answers badly or holds the bus only when the bench commands it
  assign parity_err_in = bad_parity;
  assign wait_pin = stall;
  // Column before row enters self-refresh, row before column leaves it
  always @(posedge pclk)
  begin
    pc <= cas_n;
    pr <= ras_n;
    cnt <= cnt + 1;
    // Leading strobe moved: restart the lead count
    if ((!cas_n && pc && ras_n) || (ras_n && !pr && !cas_n))
      cnt <= 1;
    // Row strobe fell under a low column strobe
    if (!ras_n && pr && !cas_n)
    begin
      lead_in <= cnt;
      in_self <= 1'b1;
    end
    // Column strobe rose after the row strobe
    if (cas_n && !pc && ras_n && in_self)
    begin
      lead_out <= cnt;
      in_self <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the parity and self-refresh block over APB.
// Assumes the defines header on the include path and the DRAM model.
`timescale 1ns/1ps
`default_nettype none
`include "bpsr_defines.svh"
`define CHK(nm, ex, gt) begin samples_checked++; if ((gt) !== (ex)) begin \
  $display("Error %s expected %h seen %h", nm, ex, gt); fails++; end end
module tb_top;
  logic pclk = 0; // 250 MHz bus clock
  logic presetn = 0; // Manual reset, low active
  logic por_n = 0; // Power-on qualifier
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 4'hf; // Byte strobes, full word unless a test narrows them
  logic [1:0] access_space = 0;
  logic ext_access = 0;
  logic [2:0] access_area = 0;
  logic halt = 0;
  logic bad_parity = 0;
  logic stall = 0;
  logic [31:0] prdata;
  logic pready, pslverr, parity_err_in, wait_pin;
  logic ras_n, cas_n, standby, bus_busy, irq, in_self;
  logic [31:0] rd; // Last read data
  logic err; // Last slave error
  int lead_in, lead_out, base, n;
  int fails = 0;
  int samples_checked = 0;
  always #2 pclk = ~pclk;
  bpsr_top u_bpsr_top (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .parity_err_in(parity_err_in),
    .access_space(access_space), .ext_access(ext_access), .access_area(access_area),
    .wait_pin(wait_pin), .halt(halt), .ras_n(ras_n), .cas_n(cas_n), .standby(standby),
    .bus_busy(bus_busy), .irq(irq));
  bpsr_dram_model u_bpsr_dram_model (.pclk(pclk), .ras_n(ras_n), .cas_n(cas_n),
    .bad_parity(bad_parity), .stall(stall), .parity_err_in(parity_err_in),
    .wait_pin(wait_pin), .lead_in(lead_in), .lead_out(lead_out), .in_self(in_self));
  // One APB transfer; an idle edge follows so back-to-back calls never clash
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed: only the watchdog ends a wait
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Reset with or without the power-on qualifier
  task automatic rst(input logic por);
    presetn <= 1'b0;
    por_n <= ~por;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    por_n <= 1'b1;
  endtask
  // Start one external cycle and count busy cycles
  task automatic cyc(input logic [2:0] ar, output int len);
    access_area <= ar;
    ext_access <= 1'b1;
    @(posedge pclk);
    ext_access <= 1'b0;
    len = 0;
    repeat (40)
    begin
      @(posedge pclk);
      if (bus_busy === 1'b1)
        len++;
    end
  endtask
  // Hold a faulty external access in the given space
  task automatic fault(input logic [1:0] sp);
    access_space <= sp;
    ext_access <= 1'b1;
    bad_parity <= 1'b1;
    repeat (6) @(posedge pclk);
    ext_access <= 1'b0;
    bad_parity <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Cuts a hang short; the tests need a few hundred cycles at most
  initial
  begin
    #40000;
    fails++;
    print_verdict();
  end
  initial
  begin
    rst(1'b1);
    apb(0, `BPSR_OFF_PARITY, 0);
    `CHK("parity reset", 16'h0000, rd[15:0])
    apb(0, 12'h020, 0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(1, `BPSR_OFF_PARITY, 32'hf800);
    apb(0, `BPSR_OFF_PARITY, 0);
    `CHK("parity rw", 16'h7800, rd[15:0])
    // High byte not strobed: the control bits must survive
    pstrb <= 4'h1;
    apb(1, `BPSR_OFF_PARITY, 32'h0);
    pstrb <= 4'hf;
    apb(0, `BPSR_OFF_PARITY, 0);
    `CHK("strobe keep", 16'h7800, rd[15:0])
    $display("test registers done");
    // Space 1 checked; a fault elsewhere must not count
    apb(1, `BPSR_OFF_PARITY, 32'h0800);
    fault(2'b10);
    apb(0, `BPSR_OFF_PARITY, 0);
    `CHK("no flag", 16'h0800, rd[15:0])
    fault(2'b01);
    apb(1, `BPSR_OFF_PARITY, 32'h0800);
    apb(0, `BPSR_OFF_PARITY, 0);
    `CHK("flag kept", 16'h8800, rd[15:0])
    apb(1, `BPSR_OFF_PARITY, 32'h0800);
    apb(0, `BPSR_OFF_PARITY, 0);
    `CHK("flag cleared", 16'h0800, rd[15:0])
    // Interrupt: masked, unmasked, then cleared
    apb(0, `BPSR_OFF_STATUS, 0);
    `CHK("status err", 1'b1, rd[0])
    `CHK("irq masked", 1'b0, irq)
    apb(1, `BPSR_OFF_MASK, 32'h1);
    @(posedge pclk);
    `CHK("irq raised", 1'b1, irq)
    apb(1, `BPSR_OFF_STATUS, 32'h1);
    @(posedge pclk);
    `CHK("irq cleared", 1'b0, irq)
    $display("test parity done");
    // Self-refresh entered while a bus cycle runs
    // Reference length with no extra states for area 0
    apb(1, `BPSR_OFF_WAIT2, 32'h0);
    cyc(3'd0, base);
    fork
      cyc(3'd0, n);
      apb(1, `BPSR_OFF_REFRESH, 32'h3);
    join
    `CHK("overlap len", base, n)
    `CHK("entry lead", `BPSR_CR_CYC, lead_in)
    `CHK("in self", 1'b1, in_self)
    apb(0, `BPSR_OFF_STATUS, 0);
    `CHK("sr active", 2'b11, {rd[3], rd[1]})
    // Row refresh after exit is only advised, so none is issued here
    apb(1, `BPSR_OFF_REFRESH, 32'h1);
    repeat (4) @(posedge pclk);
    `CHK("exit lead", `BPSR_CR_CYC, lead_out)
    `CHK("strobes up", 2'b11, {ras_n, cas_n})
    apb(0, `BPSR_OFF_STATUS, 0);
    `CHK("sr left", 2'b10, {rd[2], rd[3]})
    $display("test self-refresh done");
    // Wait states per area
    apb(1, `BPSR_OFF_WAIT2, 32'h2);
    cyc(3'd0, n);
    `CHK("area0 len", base + 2, n)
    apb(1, `BPSR_OFF_WAIT3, 32'h2);
    cyc(3'd1, n);
    `CHK("area1 len", base + 1, n)
    apb(1, `BPSR_OFF_WAIT1, 32'h4);
    stall <= 1'b1;
    // Area 1 ignores the held wait pin, area 2 honours it
    cyc(3'd1, n);
    `CHK("area1 no wait", base + 1, n)
    cyc(3'd2, n);
    stall <= 1'b0;
    `CHK("area2 waits", 1'b1, n > base)
    $display("test wait done");
    // Standby keeps self-refresh, then resets keep or clear parity
    apb(1, `BPSR_OFF_PARITY, 32'h7800);
    apb(1, `BPSR_OFF_REFRESH, 32'h3);
    apb(1, `BPSR_OFF_STANDBY, 32'h1);
    halt <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK("standby", 1'b1, standby)
    `CHK("sr in standby", 2'b00, {ras_n, cas_n})
    halt <= 1'b0;
    rst(1'b0);
    apb(0, `BPSR_OFF_PARITY, 0);
    `CHK("manual keep", 16'h7800, rd[15:0])
    rst(1'b1);
    apb(0, `BPSR_OFF_PARITY, 0);
    `CHK("power clear", 16'h0000, rd[15:0])
    $display("test reset kinds done");
    print_verdict();
  end
endmodule
`default_nettype wire
